// ===== strap_pkg.sv
/*
  constants for the power-on strap capture block: register map, field
  positions, reset values, decode codes and timing counts.
  assumes a 50 MHz system clock and a 32-bit classic wishbone bus.
*/
package strap_pkg;

  // clock and settle timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int STRAP_SETTLE_NS = 1000;
  localparam int STRAP_SETTLE_CYCLES = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // pin counts
  localparam int STRAP_PINS = 10;
  localparam int STRAP_INPUTS = 11;

  // register byte offsets
  localparam logic [7:0] OFS_STRAP_VALUE = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // strap value field positions
  localparam int POS_BOOT_LO = 0;
  localparam int POS_FLASH_CLK = 2;
  localparam int POS_WATCHDOG = 3;
  localparam int POS_DEBUG_PORT = 4;
  localparam int POS_DEBUG_MSG = 5;
  localparam int POS_PAGE_LO = 6;
  localparam int POS_MISC_LO = 8;
  localparam int POS_USB_ROLE = 16;

  // control register field positions
  localparam int POS_MSG_MUTE = 0;

  // reset values: every open pin reads as one
  localparam logic [31:0] RST_STRAP_VALUE = 32'h0001_03ff;
  localparam logic RST_MSG_MUTE = 1'b0;

  // boot sources
  localparam logic [1:0] BOOT_USB = 2'h0;
  localparam logic [1:0] BOOT_CARD = 2'h1;
  localparam logic [1:0] BOOT_NAND = 2'h2;
  localparam logic [1:0] BOOT_SERIAL = 2'h3;

  // shared "ignore" code of the two-bit option fields
  localparam logic [1:0] CODE_IGNORE = 2'h3;
  // serial flash type codes
  localparam logic [1:0] SFL_NAND_1BIT = 2'h0;
  localparam logic [1:0] SFL_NAND_4BIT = 2'h1;
  localparam logic [1:0] SFL_NOR_4BIT = 2'h2;

  // boot serial flash clock in mhz
  localparam logic [5:0] FLASH_CLK_SLOW_MHZ = 6'h1e;
  localparam logic [5:0] FLASH_CLK_FAST_MHZ = 6'h32;

  // capture sequencer states
  typedef enum logic [1:0] {
    st_settle = 2'b00,
    st_capture = 2'b01,
    st_done = 2'b10
  } cap_state_t;

endpackage

// ===== power_on_strap_capture.sv
/*
  power-on strap capture: samples the strap pins after reset, holds the
  captured word, decodes it into boot configuration, and shows it over a
  classic wishbone slave.
  assumes strap pins are asynchronous board levels and that rstn is the
  system reset; the pad drivers honour strap_pullup_en.
*/
// Function
// - captured configuration applied after every reset
// - pull-ups on throughout reset and capture
// - strap pins zero-nine map to bits zero-nine
// - bits one-zero select boot source
// - bit two selects flash clock rate
// - bit three enables watchdog after reset
// - bit four routes debug port pins
// - bit five zero enables debug messages
// - bits seven-six set nand page size
// - nand boot: bits nine-eight pick ecc
// - card boot: code three picks card port zero
// - serial boot: bits nine-eight pick flash type
// - bit sixteen follows usb role pin
// - watchdog forced on when bit three set
`timescale 1ns/1ps
module power_on_strap_capture
  import strap_pkg::*;
#(
  parameter int SETTLE_CYCLES = STRAP_SETTLE_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  // strap pins
  input wire logic [STRAP_PINS-1:0] strap_port_pins,
  input wire logic usb_port_role_pin,
  output logic strap_pullup_en,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // decoded configuration
  output logic capture_done,
  output logic [1:0] boot_source,
  output logic [5:0] boot_flash_clk_mhz,
  output logic watchdog_force_on,
  output logic debug_port_on_port_g,
  output logic debug_msg_enable,
  output logic [1:0] nand_page_size_sel,
  output logic nand_page_size_valid,
  output logic [1:0] nand_ecc_sel,
  output logic nand_ecc_valid,
  output logic card_port_one_sel,
  output logic [1:0] serial_flash_type,
  output logic usb_port0_device
);

  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

  // refuse settle counts that the sequencer counter cannot serve
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 4096) begin
    $error("settle count out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and capture sequencer

  logic [STRAP_INPUTS-1:0] sync1;
  logic [STRAP_INPUTS-1:0] sync2;
  logic [STRAP_INPUTS-1:0] sync3;
  logic [CNT_W-1:0] settle_cnt;
  cap_state_t state;
  logic [31:0] power_on_strap_value;
  logic [31:0] next_strap;
  logic capture_fire;
  logic msg_mute;

  // three-stage synchroniser; resets to the pulled-up level
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= {STRAP_INPUTS{1'b1}};
      sync2 <= {STRAP_INPUTS{1'b1}};
      sync3 <= {STRAP_INPUTS{1'b1}};
    end else begin
      sync1 <= {usb_port_role_pin, strap_port_pins};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // capture fires once the last two stages agree on every pin
  assign capture_fire = (state == st_capture) && (sync2 == sync3);

  // assemble the word: pins to low bits, role pin to bit sixteen
  always_comb begin
    next_strap = 32'h0000_0000;
    next_strap[STRAP_PINS-1:0] = sync3[STRAP_PINS-1:0];
    next_strap[POS_USB_ROLE] = sync3[STRAP_INPUTS-1];
  end

  // sequencer: settle with pull-ups on, capture, then hold
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= st_settle;
      settle_cnt <= '0;
    end else begin
      case (state)
        st_settle: begin
          if (settle_cnt == CNT_W'(SETTLE_CYCLES - 1)) begin
            state <= st_capture;
          end else begin
            settle_cnt <= settle_cnt + CNT_W'(1);
          end
        end
        st_capture: begin
          if (capture_fire) begin
            state <= st_done;
          end
        end
        st_done: begin
          state <= st_done;
        end
        default: begin
          state <= st_settle;
        end
      endcase
    end
  end

  // pull-ups stay on until the value is taken
  assign strap_pullup_en = (state != st_done);
  assign capture_done = (state == st_done);

  // captured word; loaded once per reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      power_on_strap_value <= RST_STRAP_VALUE;
    end else if (capture_fire) begin
      power_on_strap_value <= next_strap;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration decode

  // decoded fields load with the word; defaults hold until then
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      boot_source <= BOOT_SERIAL;
      boot_flash_clk_mhz <= FLASH_CLK_FAST_MHZ;
      watchdog_force_on <= 1'b1;
      debug_port_on_port_g <= 1'b1;
      nand_page_size_sel <= CODE_IGNORE;
      nand_page_size_valid <= 1'b0;
      nand_ecc_sel <= CODE_IGNORE;
      nand_ecc_valid <= 1'b0;
      card_port_one_sel <= 1'b0;
      serial_flash_type <= CODE_IGNORE;
      usb_port0_device <= 1'b1;
    end else if (capture_fire) begin
      boot_source <= next_strap[POS_BOOT_LO +: 2];
      boot_flash_clk_mhz <= next_strap[POS_FLASH_CLK] ? FLASH_CLK_FAST_MHZ
                                                       : FLASH_CLK_SLOW_MHZ;
      watchdog_force_on <= next_strap[POS_WATCHDOG];
      debug_port_on_port_g <= next_strap[POS_DEBUG_PORT];
      nand_page_size_sel <= next_strap[POS_PAGE_LO +: 2];
      nand_page_size_valid <= (next_strap[POS_PAGE_LO +: 2] != CODE_IGNORE);
      // option field meaning depends on the boot source
      nand_ecc_sel <= next_strap[POS_MISC_LO +: 2];
      nand_ecc_valid <= (next_strap[POS_BOOT_LO +: 2] == BOOT_NAND)
                        && (next_strap[POS_MISC_LO +: 2] != CODE_IGNORE);
      card_port_one_sel <= (next_strap[POS_BOOT_LO +: 2] == BOOT_CARD)
                           && (next_strap[POS_MISC_LO +: 2] != CODE_IGNORE);
      serial_flash_type <= (next_strap[POS_BOOT_LO +: 2] == BOOT_SERIAL)
                           ? next_strap[POS_MISC_LO +: 2] : CODE_IGNORE;
      usb_port0_device <= next_strap[POS_USB_ROLE];
    end
  end

  // debug messages: strap zero enables, software may still mute
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      debug_msg_enable <= 1'b0;
    end else begin
      debug_msg_enable <= (state == st_done) && !power_on_strap_value[POS_DEBUG_MSG]
                          && !msg_mute;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  logic bus_req;
  logic wr_ctrl;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl = bus_req && wb_we_i && (wb_adr_i == OFS_CONTROL) && wb_sel_i[0];

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // control register: message mute
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      msg_mute <= RST_MSG_MUTE;
    end else if (wr_ctrl) begin
      msg_mute <= wb_dat_i[POS_MSG_MUTE];
    end
  end

  // read data; unmapped offsets read zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        OFS_STRAP_VALUE: wb_dat_o <= power_on_strap_value;
        OFS_CONTROL: wb_dat_o <= {31'h0000_0000, msg_mute};
        OFS_STATUS: wb_dat_o <= {28'h000_0000, debug_msg_enable, state == st_done, state};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  a_pullup_reset: assert property (@(posedge mclk) disable iff (!rstn)
    (state != st_done) |-> strap_pullup_en)
    else $error("pull-up released before capture");

  a_settle_window: assert property (@(posedge mclk) disable iff (!rstn)
    (state == st_settle) |-> (settle_cnt < CNT_W'(SETTLE_CYCLES)))
    else $error("settle counter overran");

  a_value_hold: assert property (@(posedge mclk) disable iff (!rstn)
    (state == st_done) && $past(state == st_done) |-> $stable(power_on_strap_value))
    else $error("strap value changed after capture");

  a_pin_map: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(capture_done) |-> power_on_strap_value[9:0] == $past(sync3[9:0])
      && power_on_strap_value[POS_USB_ROLE] == $past(sync3[10]))
    else $error("strap bits not mapped from pins");

  a_defaults_pre: assert property (@(posedge mclk) disable iff (!rstn)
    !capture_done |-> (power_on_strap_value == RST_STRAP_VALUE) && watchdog_force_on)
    else $error("defaults not held before capture");

  a_boot_source: assert property (@(posedge mclk) disable iff (!rstn)
    capture_done |-> boot_source == power_on_strap_value[1:0])
    else $error("boot source mismatch");

  a_flash_clk: assert property (@(posedge mclk) disable iff (!rstn)
    capture_done |-> boot_flash_clk_mhz == (power_on_strap_value[2] ? 6'h32 : 6'h1e))
    else $error("flash clock select mismatch");

  a_watchdog_on: assert property (@(posedge mclk) disable iff (!rstn)
    capture_done |-> watchdog_force_on == power_on_strap_value[3])
    else $error("watchdog force mismatch");

  a_debug_port: assert property (@(posedge mclk) disable iff (!rstn)
    capture_done |-> debug_port_on_port_g == power_on_strap_value[4])
    else $error("debug port route mismatch");

  a_debug_msg: assert property (@(posedge mclk) disable iff (!rstn)
    ##1 debug_msg_enable == ($past(capture_done) && !$past(power_on_strap_value[5])
      && !$past(msg_mute)))
    else $error("debug message gate mismatch");

  a_page_size: assert property (@(posedge mclk) disable iff (!rstn)
    capture_done |-> nand_page_size_sel == power_on_strap_value[7:6]
      && nand_page_size_valid == (power_on_strap_value[7:6] != 2'h3))
    else $error("page size mismatch");

  a_nand_ecc: assert property (@(posedge mclk) disable iff (!rstn)
    capture_done && nand_ecc_valid |-> power_on_strap_value[1:0] == 2'h2
      && nand_ecc_sel != 2'h3)
    else $error("ecc valid outside nand boot");

  a_card_port: assert property (@(posedge mclk) disable iff (!rstn)
    capture_done && power_on_strap_value[1:0] == 2'h1
      |-> card_port_one_sel == (power_on_strap_value[9:8] != 2'h3))
    else $error("card port select mismatch");

  a_serial_type: assert property (@(posedge mclk) disable iff (!rstn)
    capture_done && power_on_strap_value[1:0] == 2'h3
      |-> serial_flash_type == power_on_strap_value[9:8])
    else $error("serial flash type mismatch");

  a_usb_role: assert property (@(posedge mclk) disable iff (!rstn)
    capture_done |-> usb_port0_device == power_on_strap_value[16])
    else $error("usb role mismatch");

  a_bus_ack: assert property (@(posedge mclk) disable iff (!rstn)
    bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a one-cycle answer");

  a_settle_exit: assert property (@(posedge mclk) disable iff (!rstn)
    (state == st_settle) && (settle_cnt == CNT_W'(SETTLE_CYCLES - 1))
      |=> state == st_capture)
    else $error("settle did not end on count");

  a_fire_agree: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(capture_done) |-> $past(state == st_capture) && $past(sync2 == sync3))
    else $error("capture without agreeing stages");

  a_done_sticky: assert property (@(posedge mclk) disable iff (!rstn)
    capture_done |=> capture_done)
    else $error("capture done dropped without reset");

  a_pullup_off: assert property (@(posedge mclk) disable iff (!rstn)
    capture_done |-> !strap_pullup_en)
    else $error("pull-up still on after capture");

  a_ctrl_write: assert property (@(posedge mclk) disable iff (!rstn)
    wr_ctrl |=> msg_mute == $past(wb_dat_i[POS_MSG_MUTE]))
    else $error("control write not applied");

  a_ack_from_req: assert property (@(posedge mclk) disable iff (!rstn)
    wb_ack_o |-> $past(bus_req))
    else $error("ack without a taken request");

  a_read_strap: assert property (@(posedge mclk) disable iff (!rstn)
    bus_req && !wb_we_i && (wb_adr_i == OFS_STRAP_VALUE)
      |=> wb_dat_o == $past(power_on_strap_value))
    else $error("strap value read mismatch");

  a_card_default: assert property (@(posedge mclk) disable iff (!rstn)
    capture_done && (boot_source != BOOT_CARD) |-> !card_port_one_sel)
    else $error("card port one outside card boot");

  a_serial_ignore: assert property (@(posedge mclk) disable iff (!rstn)
    capture_done && (boot_source != BOOT_SERIAL) |-> serial_flash_type == CODE_IGNORE)
    else $error("serial type set outside serial boot");

endmodule

// ===== board_straps.sv
/*
  board strap model: external pull-downs on the strap pins and the usb
  role pin. assumes the pad pull-ups are on while strap_pullup_en is high.
*/
`timescale 1ns/1ps
module board_straps (
  input wire logic mclk,
  input wire logic strap_pullup_en,
  input wire logic [9:0] pull_down,
  input wire logic usb_pull_down,
  output logic [9:0] strap_port_pins,
  output logic usb_port_role_pin
);
  logic wander = 1'b0;
  ////////////////////////////////////////
  // open pin with pull-up off floats: show a level that moves every cycle
  always_ff @(posedge mclk) begin
    wander <= ~wander;
  end
  ////////////////////////////////////////
  // pulled-down pins read low, open strap pins follow the pad pull-up, an open usb role pin always reads high
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      strap_port_pins[i] = pull_down[i] ? 1'b0 : (strap_pullup_en ? 1'b1 : wander);
    end
    usb_port_role_pin = ~usb_pull_down;
  end
endmodule

// ===== testbench.sv
/*
  self-checking bench for the strap capture block: board model, wishbone
  master tasks, one task per scenario. assumes SETTLE_CYCLES is set to 2.
*/
`timescale 1ns/1ps
module testbench;
  import strap_pkg::*;
  logic mclk;
  logic rstn;
  logic [9:0] pull_down;
  logic usb_pull_down;
  logic [9:0] strap_port_pins;
  logic usb_port_role_pin;
  logic strap_pullup_en;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic capture_done;
  logic [1:0] boot_source;
  logic [5:0] boot_flash_clk_mhz;
  logic watchdog_force_on;
  logic debug_port_on_port_g;
  logic debug_msg_enable;
  logic [1:0] nand_page_size_sel;
  logic nand_page_size_valid;
  logic [1:0] nand_ecc_sel;
  logic nand_ecc_valid;
  logic card_port_one_sel;
  logic [1:0] serial_flash_type;
  logic usb_port0_device;
  logic [31:0] rd;
  logic [3:0] sel_next = 4'hf;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  ////////////////////////////////////////
  board_straps board (.mclk, .strap_pullup_en, .pull_down, .usb_pull_down,
    .strap_port_pins, .usb_port_role_pin);
  power_on_strap_capture #(.SETTLE_CYCLES(2)) uut (.mclk, .rstn, .strap_port_pins,
    .usb_port_role_pin, .strap_pullup_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .capture_done, .boot_source,
    .boot_flash_clk_mhz, .watchdog_force_on, .debug_port_on_port_g, .debug_msg_enable,
    .nand_page_size_sel, .nand_page_size_valid, .nand_ecc_sel, .nand_ecc_valid,
    .card_port_one_sel, .serial_flash_type, .usb_port0_device);
  ////////////////////////////////////////
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one classic cycle: hold the request until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel_next;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    check(n, 2);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wait_capture();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (capture_done !== 1'b1 && n < 40);
    check(n < 40, 1);
    repeat (2) @(posedge mclk);
  endtask
  // reset with a new board setting, pull-ups checked while in reset
  task automatic power_up(input logic [9:0] pd, input logic upd);
    @(posedge mclk);
    rstn <= 1'b0;
    pull_down <= pd;
    usb_pull_down <= upd;
    repeat (2) @(posedge mclk);
    check(strap_pullup_en, 1);
    rstn <= 1'b1;
    wait_capture();
  endtask
  task automatic check_config(input logic [9:0] v, input logic u);
    logic [1:0] m;
    m = v[9:8];
    wb(1'b0, OFS_STRAP_VALUE, 32'h0);
    check(rd, {15'h0, u, 6'h0, v});
    check(usb_port0_device, u);
    check(boot_source, v[1:0]);
    check(boot_flash_clk_mhz, v[2] ? FLASH_CLK_FAST_MHZ : FLASH_CLK_SLOW_MHZ);
    check({watchdog_force_on, debug_port_on_port_g}, {v[3], v[4]});
    check(debug_msg_enable, !v[5]);
    check({nand_page_size_valid, nand_page_size_sel}, {v[7:6] != CODE_IGNORE, v[7:6]});
    check({nand_ecc_valid, nand_ecc_sel}, {v[1:0] == BOOT_NAND && m != CODE_IGNORE, m});
    check(card_port_one_sel, v[1:0] == BOOT_CARD && m != CODE_IGNORE);
    check(serial_flash_type, v[1:0] == BOOT_SERIAL ? m : CODE_IGNORE);
    check(strap_pullup_en, 0);
  endtask
  ////////////////////////////////////////
  // all pins open: every field at its default
  task automatic test_defaults();
    wait_capture();
    check_config(10'h3ff, 1'b1);
  endtask
  // every boot source against every option code, reset between them
  task automatic test_table();
    logic [9:0] v;
    for (int i = 0; i < 16; i++) begin
      v = {i[3:2], i[2:1] ^ 2'b01, i[0], i[3], i[1], i[2], i[1:0]};
      power_up(~v, ~(i[0] ^ i[3]));
      check_config(v, i[0] ^ i[3]);
    end
  endtask
  // pins change after capture, write to the read-only word, mute, unmapped
  task automatic test_hold();
    power_up(10'h020, 1'b0);
    pull_down <= 10'h3ff;
    usb_pull_down <= 1'b1;
    wb(1'b1, OFS_STRAP_VALUE, 32'h0);
    repeat (5) @(posedge mclk);
    check_config(10'h3df, 1'b1);
    wb(1'b1, OFS_CONTROL, 32'h1);
    repeat (2) @(posedge mclk);
    check(debug_msg_enable, 0);
    sel_next = 4'he;
    wb(1'b1, OFS_CONTROL, 32'h0);
    sel_next = 4'hf;
    wb(1'b0, OFS_CONTROL, 32'h0);
    check(rd, 32'h1);
    wb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h6);
    wb(1'b0, 8'hfc, 32'h0);
    check(rd, 32'h0);
  endtask
  ////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    pull_down = 10'h0;
    usb_pull_down = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    test_defaults();
    test_table();
    test_hold();
    end_sim();
  end
endmodule
